// ---- include/fpc_params.svh ----
// Purpose: Constants of the fault protection controller
// Assumes: 200 MHz logic clock
// Notes:   Offsets are byte addresses on classic Wishbone
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

`define FPC_CLK_MHZ          200
`define FPC_LIMIT_TIME_US    2600
`define FPC_GUARD_TIME_US    4000
`define FPC_STUCK_CYC        2000

`define FPC_REG_CTRL         8'h00
`define FPC_REG_STATUS       8'h04

`define FPC_CTRL_MODE_LSB    0
`define FPC_CTRL_MODE_MSB    1
`define FPC_CTRL_LIMIT_BIT   2
`define FPC_CTRL_RESET       3'h0

`define FPC_MODE_BRIDGED     2'h0
`define FPC_MODE_PARALLEL    2'h1
`define FPC_MODE_SINGLE      2'h2

`endif

// ---- include/fpc_pkg.sv ----
// Purpose: Types of the fault protection controller
// Assumes: Nothing beyond the params header
// Notes:   Four half-bridges A..D map to bits 0..3
package fpc_pkg;

   typedef logic [3:0] fpc_hb_t;

   typedef enum logic [1:0] {
      FPC_ST_RESET,
      FPC_ST_HOLD,
      FPC_ST_START,
      FPC_ST_RUN
   } fpc_state_t;

endpackage : fpc_pkg

// ---- rtl/fpc_ctrl.sv ----
// Purpose: Protection and error reporting of a four half-bridge power stage
// Assumes: Comparator outputs and the reset pin are asynchronous
// Notes:   Register map CTRL (mode, limit mode) and STATUS on Wishbone
// Function
// [RL1] Warning low above 125C, releases under hysteresis
// [RL2] Supply undervoltage: all outputs Hi-Z, fault low
// [RL3] Undervoltage recovery needs no reset
// [RL4] Power-on clear wipes overload state
// [RL5] Fault and warning are active-low open drain
// [RL6] Fault/warning pair encodes the condition
// [RL7] Global fault stops all, latched until reset toggle
// [RL8] Channel fault stops only affected channels
// [RL9] Reset low forces fault flag high
// [RL10] Host releases reset only when warning high
// [RL11] Host waits 4 ms after fault fall
// [RL12] Reset low puts every transistor off
// [RL13] Reset low: weak pulldown unless single-ended
// [RL14] Reset rise clears latches, starts, then switches
// [RL15] Current limit over 2.6 ms latches channel off
// [RL16] Latch mode overcurrent shuts channel at once
// [RL17] Limit mode overcurrent flips state, self-clearing
// [RL18] Bootstrap low turns off high side only
// [RL19] Stuck input PWM Hi-Z, self-clearing, unreported
// [RL20] Thermal shutdown is global and latched
// [RL21] Logic supply power-on clear is global, self-clearing
// [RL22] Clip indicator follows pulse skipping
// [RL23] Thermal trip above 155C latches and Hi-Z
// [RL24] All async inputs synchronised first
// [RL25] Guard counter ignores too early reset release
`timescale 1ns/10ps
`include "fpc_params.svh"

module fpc_ctrl #(
   parameter logic [19:0] CUR_LIMIT   = 20'(`FPC_LIMIT_TIME_US * `FPC_CLK_MHZ),
   parameter logic [19:0] GUARD_LIMIT = 20'(`FPC_GUARD_TIME_US * `FPC_CLK_MHZ),
   parameter logic [11:0] STUCK_LIMIT = 12'(`FPC_STUCK_CYC)
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            sys_rst,
   // Wishbone slave
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic            wb_we_i,
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   output logic                 wb_ack_o,
   // Device reset pin
   input  wire logic            rst_in_n,
   // Analog indications and PWM inputs
   input  wire logic            temp_warn_hi,
   input  wire logic            temp_crit_hi,
   input  wire logic [1:0]      gate_drive_supply_low,
   input  wire logic [1:0]      power_stage_supply_low,
   input  wire logic            internal_analog_supply_low,
   input  wire logic            internal_logic_supply_low,
   input  wire fpc_pkg::fpc_hb_t over_current,
   input  wire fpc_pkg::fpc_hb_t bootstrap_cap_low,
   input  wire fpc_pkg::fpc_hb_t pwm_in,
   input  wire logic            clip_skip,
   input  wire logic            startup_done,
   // Open-drain status pins
   input  wire logic            fault_n_in,
   output logic                 fault_n_out,
   output logic                 fault_n_oe,
   input  wire logic            thermal_warning_n_in,
   output logic                 thermal_warning_n_out,
   output logic                 thermal_warning_n_oe,
   input  wire logic            clip_n_in,
   output logic                 clip_n_out,
   output logic                 clip_n_oe,
   // Power stage control
   output fpc_pkg::fpc_hb_t     hb_hiz,
   output fpc_pkg::fpc_hb_t     hs_off,
   output fpc_pkg::fpc_hb_t     weak_pulldown,
   output fpc_pkg::fpc_hb_t     flip_state,
   output logic                 switch_en
);
   import fpc_pkg::*;

   localparam int NS = 26;

   // Channels that share a bridge go down together
   function automatic fpc_hb_t chan_map(input logic [1:0] mode, input fpc_hb_t f);
      fpc_hb_t r;
      r = {{2{|f[3:2]}}, {2{|f[1:0]}}};
      if (mode == `FPC_MODE_PARALLEL && |f)
         r = 4'hF;
      return r;
   endfunction : chan_map

   // Synchronisers: three stages, change taken when 2nd and 3rd agree
   wire logic [NS-1:0] async_in = {fault_n_in, thermal_warning_n_in, clip_n_in,
      startup_done, clip_skip, internal_logic_supply_low, internal_analog_supply_low,
      power_stage_supply_low, gate_drive_supply_low, temp_crit_hi, temp_warn_hi,
      rst_in_n, bootstrap_cap_low, over_current, pwm_in};
   logic [NS-1:0] s1;
   logic [NS-1:0] s2;
   logic [NS-1:0] s3;
   logic [NS-1:0] sf;

   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               s1[gi] <= 1'b0;
               s2[gi] <= 1'b0;
               s3[gi] <= 1'b0;
               sf[gi] <= 1'b0;
            end else begin
               s1[gi] <= async_in[gi];
               s2[gi] <= s1[gi];
               s3[gi] <= s2[gi];
               if (s2[gi] == s3[gi])
                  sf[gi] <= s3[gi]; // RL24
            end
         end
      end
   endgenerate

   // Filtered view, bit order as in async_in
   wire fpc_hb_t  pwm_s      = sf[3:0];
   wire fpc_hb_t  oc_s       = sf[7:4];
   wire fpc_hb_t  boot_s     = sf[11:8];
   wire logic     rst_high   = sf[12];
   wire logic     warn_s     = sf[13];
   wire logic     crit_s     = sf[14];
   wire logic [1:0] gate_s   = sf[16:15];
   wire logic [1:0] stage_s  = sf[18:17];
   wire logic     analog_s   = sf[19];
   wire logic     uv_any     = (|gate_s) | (|stage_s) | analog_s; // RL2
   wire logic     por        = sf[20];
   wire logic     clip_s     = sf[21];
   wire logic     start_s    = sf[22];
   wire logic [2:0] pin_s    = sf[25:23];

   // Control register
   logic [2:0] ctrl;
   wire logic [1:0] mode       = ctrl[`FPC_CTRL_MODE_MSB:`FPC_CTRL_MODE_LSB];
   wire logic       limit_mode = ctrl[`FPC_CTRL_LIMIT_BIT];

   fpc_state_t state;
   fpc_state_t next_state;
   logic       therm_lat;
   fpc_hb_t    ovl_lat;
   fpc_hb_t    oc_lat;
   fpc_hb_t    stuck;
   fpc_hb_t    pwm_q;
   logic       fault_low;
   logic [19:0] guard_cnt;

   wire logic guard_done = (guard_cnt == GUARD_LIMIT);
   wire logic accept     = (state == FPC_ST_RESET) && rst_high && guard_done; // RL14
   wire logic fault_cond = uv_any | por | therm_lat | (|ovl_lat) | (|oc_lat); // RL6
   wire logic next_fault_low = fault_cond & rst_high; // RL9
   wire logic in_reset   = (state == FPC_ST_RESET) || (state == FPC_ST_HOLD);

   always_comb begin
      next_state = state;
      case (state)
         FPC_ST_RESET: begin
            if (rst_high)
               next_state = guard_done ? FPC_ST_START : FPC_ST_HOLD; // RL25
         end
         FPC_ST_HOLD: begin
            if (!rst_high)
               next_state = FPC_ST_RESET;
         end
         FPC_ST_START: begin
            if (!rst_high)
               next_state = FPC_ST_RESET;
            else if (start_s)
               next_state = FPC_ST_RUN; // RL14
         end
         FPC_ST_RUN: begin
            if (!rst_high)
               next_state = FPC_ST_RESET;
         end
         default: next_state = FPC_ST_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         state <= FPC_ST_RESET;
      else
         state <= next_state;
   end

   // Thermal latch: set wins over the clear of an accepted release
   always_ff @(posedge clk) begin
      if (sys_rst)
         therm_lat <= 1'b0;
      else
         therm_lat <= crit_s | (therm_lat & ~accept); // RL20 RL23 RL7
   end

   // Guard timer from the fault falling edge; saturated means ready
   always_ff @(posedge clk) begin
      if (sys_rst)
         guard_cnt <= GUARD_LIMIT;
      else if (next_fault_low && !fault_low)
         guard_cnt <= 20'h00000; // RL25
      else if (!guard_done)
         guard_cnt <= guard_cnt + 20'h00001;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_low <= 1'b0;
         pwm_q     <= 4'h0;
      end else begin
         fault_low <= next_fault_low;
         pwm_q     <= pwm_s;
      end
   end

   // Per-channel overload, overcurrent and stuck-input detection
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         logic [19:0] lim_cnt;
         logic [11:0] stk_cnt;
         wire logic   lim_on   = oc_s[gi] & limit_mode;
         wire logic   lim_full = (lim_cnt == CUR_LIMIT);
         wire logic   stk_full = (stk_cnt == STUCK_LIMIT);
         wire logic   pwm_edge = (pwm_s[gi] != pwm_q[gi]);
         // Set terms win over the clear of an accepted release
         wire logic   ovl_set  = lim_on & lim_full;
         wire logic   ovl_keep = ovl_lat[gi] & ~accept & ~por;
         // Overcurrent seen in reset is not latched
         wire logic   oc_set   = oc_s[gi] & ~limit_mode & ~in_reset;
         wire logic   oc_keep  = oc_lat[gi] & ~accept & ~por;
         always_ff @(posedge clk) begin
            if (sys_rst || !lim_on)
               lim_cnt <= 20'h00000;
            else if (!lim_full)
               lim_cnt <= lim_cnt + 20'h00001;
         end
         always_ff @(posedge clk) begin
            if (sys_rst)
               ovl_lat[gi] <= 1'b0;
            else
               ovl_lat[gi] <= ovl_set | ovl_keep; // RL15 RL4
         end
         always_ff @(posedge clk) begin
            if (sys_rst)
               oc_lat[gi] <= 1'b0;
            else
               oc_lat[gi] <= oc_set | oc_keep; // RL16 RL4
         end
         // Any input edge restarts the frame timer
         always_ff @(posedge clk) begin
            if (sys_rst || pwm_edge)
               stk_cnt <= 12'h000;
            else if (!stk_full)
               stk_cnt <= stk_cnt + 12'h001;
         end
         assign stuck[gi] = stk_full; // RL19
      end
   endgenerate

   // Power stage drive
   wire logic    global_off = uv_any | por | therm_lat | (state != FPC_ST_RUN); // RL2 RL21 RL12
   wire fpc_hb_t chan_off   = chan_map(mode, ovl_lat | oc_lat) | stuck; // RL8
   wire fpc_hb_t next_hiz   = global_off ? 4'hF : chan_off; // RL7 RL3
   wire fpc_hb_t next_pd    = (in_reset && mode != `FPC_MODE_SINGLE) ? 4'hF : 4'h0; // RL13

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hb_hiz        <= 4'hF;
         hs_off        <= 4'h0;
         weak_pulldown <= 4'h0;
         flip_state    <= 4'h0;
         switch_en     <= 1'b0;
      end else begin
         hb_hiz        <= next_hiz;
         hs_off        <= boot_s & ~next_hiz; // RL18
         weak_pulldown <= next_pd;
         flip_state    <= oc_s & {4{limit_mode}} & ~next_hiz; // RL17
         switch_en     <= ~&next_hiz;
      end
   end

   // Open-drain pins: drive low only when asserted
   assign fault_n_out           = 1'b0; // RL5
   assign thermal_warning_n_out = 1'b0;
   assign clip_n_out            = 1'b0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_n_oe           <= 1'b0;
         thermal_warning_n_oe <= 1'b0;
         clip_n_oe            <= 1'b0;
      end else begin
         fault_n_oe           <= next_fault_low; // RL6 RL9
         thermal_warning_n_oe <= warn_s | crit_s; // RL1
         clip_n_oe            <= clip_s & (state == FPC_ST_RUN); // RL22
      end
   end

   // Wishbone slave: one wait state, unmapped reads zero
   wire logic bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic sel_ctrl = (wb_adr_i == `FPC_REG_CTRL);
   wire logic sel_stat = (wb_adr_i == `FPC_REG_STATUS);
   // Bits 1:0 read as pin levels, high while idle
   wire logic [31:0] status = {
      5'h00,
      pin_s,
      2'h0,
      stuck,
      oc_lat,
      ovl_lat,
      2'(state),
      1'b0,
      therm_lat,
      por,
      uv_any,
      guard_done,
      fault_low,
      ~thermal_warning_n_oe,
      ~fault_n_oe
   };
   wire logic [31:0] rd_mux = sel_ctrl ? {29'h0, ctrl} : sel_stat ? status : 32'h0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl     <= `FPC_CTRL_RESET;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i)
            wb_dat_o <= rd_mux;
         if (bus_req && wb_we_i && sel_ctrl && wb_sel_i[0])
            ctrl <= wb_dat_i[2:0];
      end
   end

endmodule : fpc_ctrl

// ---- testbench/fpc_ctrl_asserts.sv ----
// Purpose: Port assertions of the fault protection controller
// Assumes: Inputs reach the logic 4 clocks late
// Notes:   Windows of 7 or 8 cycles cover filter and output flop
`timescale 1ns/10ps
module fpc_ctrl_asserts (
   // Clock and reset
   input wire logic             clk,
   input wire logic             sys_rst,
   // Watched inputs
   input wire logic             rst_in_n,
   input wire logic             temp_warn_hi,
   input wire logic             temp_crit_hi,
   input wire logic [1:0]       gate_drive_supply_low,
   input wire logic             clip_skip,
   // Watched outputs
   input wire logic             fault_n_out,
   input wire logic             fault_n_oe,
   input wire logic             thermal_warning_n_oe,
   input wire logic             clip_n_oe,
   input wire fpc_pkg::fpc_hb_t hb_hiz,
   input wire logic             switch_en
);
   import fpc_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_rst_low;
      (!rst_in_n)[*7];
   endsequence
   // Reset pin held high so the flag is not masked
   sequence s_uv_run;
      (gate_drive_supply_low != 2'h0 && rst_in_n)[*8];
   endsequence
   a_uv_all_hiz: assert property (s_uv_run |-> hb_hiz == 4'hF)
      else $error("outputs not Hi-Z on undervoltage");
   a_uv_flag_low: assert property (s_uv_run |-> fault_n_oe)
      else $error("fault flag idle on undervoltage");
   a_rst_flag_high: assert property (s_rst_low |-> !fault_n_oe)
      else $error("fault flag driven during reset");
   a_rst_fets_off: assert property (s_rst_low |-> hb_hiz == 4'hF && !switch_en)
      else $error("power stage active during reset");
   a_warn_set: assert property (temp_warn_hi[*7] |-> thermal_warning_n_oe)
      else $error("warning missing while hot");
   a_warn_clear: assert property ((!temp_warn_hi)[*7] |-> !thermal_warning_n_oe)
      else $error("warning stuck while cool");
   a_trip_all_hiz: assert property (temp_crit_hi[*7] |-> hb_hiz == 4'hF)
      else $error("outputs not Hi-Z on thermal trip");
   a_flag_drive_low: assert property (fault_n_oe |-> !fault_n_out)
      else $error("fault pin driven high");
   a_clip_quiet: assert property ((!clip_skip)[*7] |-> !clip_n_oe)
      else $error("clip without pulse skipping");
endmodule : fpc_ctrl_asserts

bind fpc_ctrl fpc_ctrl_asserts u_chk (.clk, .sys_rst, .rst_in_n, .temp_warn_hi, .temp_crit_hi,
   .gate_drive_supply_low, .clip_skip, .fault_n_out, .fault_n_oe, .thermal_warning_n_oe,
   .clip_n_oe, .hb_hiz, .switch_en);

// ---- testbench/fpc_ctrl_test.sv ----
// Purpose: Self-checking bench of the fault protection controller
// Assumes: Host model owns the reset pin and PWM inputs
// Notes:   Short timer values keep each restart near 80 cycles
`timescale 1ns/10ps
module fpc_ctrl_test;
   import fpc_pkg::*;
   logic        clk = 1'h0, sys_rst = 1'h1, cyc = 1'h0, we = 1'h0, tw = 1'h0, tc = 1'h0;
   logic        lsl = 1'h0, asl = 1'h0, clip = 1'h0, sdone = 1'h0, hold = 1'h1, early = 1'h0;
   logic        ack, rst_n, f_oe, w_oe, c_oe, sw, fo, wo, co;
   logic [1:0]  gdl = 2'h0, psl = 2'h0, mode = 2'h0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   fpc_hb_t     oc = 4'h0, boot = 4'h0, stop = 4'h0, sel = 4'hF, pwm, hiz, hso, wpd, flip;
   int          fail_count = 0, comparisons = 0, ch, k;
   wire         f_pin = !f_oe;
   wire         w_pin = !w_oe;
   initial forever #2.5 clk = ~clk;
   fpc_host_model #(.GUARD(30)) u_host (.clk(clk), .fault_n(f_pin), .warn_n(w_pin), .hold(hold),
      .early(early), .pwm_stop(stop), .rst_n(rst_n), .pwm(pwm));
   fpc_ctrl #(.CUR_LIMIT(20'h14), .GUARD_LIMIT(20'h1E), .STUCK_LIMIT(12'h010)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
      .rst_in_n(rst_n), .temp_warn_hi(tw), .temp_crit_hi(tc), .gate_drive_supply_low(gdl),
      .power_stage_supply_low(psl), .internal_analog_supply_low(asl),
      .internal_logic_supply_low(lsl), .over_current(oc), .bootstrap_cap_low(boot),
      .pwm_in(pwm), .clip_skip(clip), .startup_done(sdone), .fault_n_in(f_pin),
      .fault_n_out(fo), .fault_n_oe(f_oe), .thermal_warning_n_in(w_pin),
      .thermal_warning_n_out(wo), .thermal_warning_n_oe(w_oe), .clip_n_in(!c_oe),
      .clip_n_out(co), .clip_n_oe(c_oe), .hb_hiz(hiz), .hs_off(hso), .weak_pulldown(wpd),
      .flip_state(flip), .switch_en(sw));
   function automatic fpc_hb_t pair_of(input logic [1:0] m, input int c);
      return (m == 2'h1) ? 4'hF : ((c < 2) ? 4'h3 : 4'hC);
   endfunction : pair_of
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'h1);
      q = rdat;
      cyc <= 1'h0;
   endtask : wb
   task automatic wait_run();
      int n = 0;
      while ((sw !== 1'h1 || hiz !== 4'h0) && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_run
   task automatic restart();
      hold <= 1'h1;
      sdone <= 1'h0;
      step(12);
      chk("rst flag", 32'h0, f_oe);
      chk("rst hiz", 32'hF, hiz);
      chk("pulldown", (mode == 2'h2) ? 32'h0 : 32'hF, wpd);
      hold <= 1'h0;
      step(60);
      chk("no switch", 32'h0, sw);
      sdone <= 1'h1;
      wait_run();
      chk("run", 32'h1, {hiz, sw});
   endtask : restart
   initial begin
      void'($urandom(50));
      step(20);
      sys_rst <= 1'h0;
      wb(1'h0, 8'h00, 32'h0);
      chk("ctrl reset", 32'h0, q);
      wb(1'h1, 8'h40, 32'hFFFF_FFFF);
      wb(1'h0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, q);
      sel <= 4'hE;
      wb(1'h1, 8'h00, 32'h7);
      sel <= 4'hF;
      wb(1'h0, 8'h00, 32'h0);
      chk("sel drop", 32'h0, q);
      for (k = 2; k >= 0; k--) begin
         mode = 2'(k);
         wb(1'h1, 8'h00, {30'h0, mode});
         wb(1'h0, 8'h00, 32'h0);
         chk("ctrl", {30'h0, mode}, q & 32'h7);
         restart();
      end
      wb(1'h0, 8'h04, 32'h0);
      chk("status", 32'h0700030B, q);
      chk("od low", 32'h0, {fo, wo, co});
      for (k = 0; k < 4; k++) begin
         mode = 2'($urandom_range(0, 1));
         ch = $urandom_range(0, 3);
         wb(1'h1, 8'h00, {30'h0, mode});
         oc <= 4'(1 << ch);
         step(10);
         chk("oc hiz", pair_of(mode, ch), hiz);
         chk("oc other", (mode != 2'h1), sw);
         chk("oc flag", 32'h1, f_oe);
         oc <= 4'h0;
         step(10);
         chk("oc latch", pair_of(mode, ch), hiz);
         if (k == 0) begin
            early <= 1'h1;
            hold <= 1'h1;
            step(2);
            hold <= 1'h0;
            step(40);
            chk("early", 32'h0, sw);
            early <= 1'h0;
         end
         restart();
      end
      wb(1'h1, 8'h00, 32'h4);
      oc <= 4'h4;
      step(10);
      chk("flip", 32'h4, flip);
      chk("flip flag", 32'h0, f_oe);
      step(30);
      chk("limit hiz", 32'hC, hiz);
      chk("limit flag", 32'h1, f_oe);
      oc <= 4'h0;
      restart();
      wb(1'h1, 8'h00, 32'h0);
      tw <= 1'h1;
      step(10);
      chk("warn", 32'h1, {f_oe, w_oe});
      tc <= 1'h1;
      step(10);
      chk("trip hiz", 32'hF, hiz);
      chk("trip pins", 32'h3, {f_oe, w_oe});
      tc <= 1'h0;
      tw <= 1'h0;
      step(10);
      chk("trip latch", 32'h2, {f_oe, w_oe});
      restart();
      for (k = 0; k < 4; k++) begin
         gdl <= (k == 0) ? 2'($urandom_range(1, 3)) : 2'h0;
         psl <= (k == 1) ? 2'($urandom_range(1, 3)) : 2'h0;
         lsl <= (k == 2);
         asl <= (k == 3);
         oc <= 4'(k == 2);
         step(10);
         chk("uv hiz", 32'hF, hiz);
         chk("uv flag", 32'h1, f_oe);
         oc <= 4'h0;
         step(4);
         gdl <= 2'h0;
         psl <= 2'h0;
         lsl <= 1'h0;
         asl <= 1'h0;
         wait_run();
         chk("uv resume", 32'h0, hiz);
      end
      stop <= 4'h2;
      step(40);
      chk("stuck hiz", 32'h1, hiz[1]);
      chk("stuck flag", 32'h0, f_oe);
      stop <= 4'h0;
      wait_run();
      chk("stuck end", 32'h0, hiz);
      boot <= 4'h8;
      clip <= 1'h1;
      step(10);
      chk("boot", 32'h8, {hiz, hso});
      chk("clip", 32'h1, c_oe);
      boot <= 4'h0;
      clip <= 1'h0;
      step(10);
      chk("clip end", 32'h0, c_oe);
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end
endmodule : fpc_ctrl_test

// ---- testbench/fpc_host_model.sv ----
// Purpose: Host controller and PWM source beside the protection block
// Assumes: Fault and warning pins pulled up, read as levels
// Notes:   early lets a scenario release reset before the guard time
`timescale 1ns/10ps
module fpc_host_model #(
   parameter int GUARD = 30
) (
   // Clock
   input  wire logic       clk,
   // Pins and commands
   input  wire logic       fault_n,
   input  wire logic       warn_n,
   input  wire logic       hold,
   input  wire logic       early,
   input  wire logic [3:0] pwm_stop,
   // Drives
   output logic            rst_n,
   output logic [3:0]      pwm
);
   int   since = 1000;
   int   low_cyc = 0;
   logic fault_d = 1'h1;
   logic ph = 1'h0;
   initial rst_n = 1'h0;
   initial pwm = 4'h0;
   always @(posedge clk) begin
      fault_d <= fault_n;
      since <= (fault_d && !fault_n) ? 0 : since + 1;
      low_cyc <= rst_n ? 0 : low_cyc + 1;
      ph <= ~ph;
      // Half rate so every level outlasts the pin filter
      if (ph)
         pwm <= pwm ^ ~pwm_stop;
      if (hold)
         rst_n <= 1'h0;
      else if (!rst_n && low_cyc >= 8 && warn_n && (early || since > GUARD + 4))
         rst_n <= 1'h1;
   end
endmodule : fpc_host_model
